//--- rtl/cwg_pkg.sv
package cwg_pkg;

	// Byte addresses of the software-visible registers.
	localparam logic [7:0] OFF_CONTROL_FIRST  = 8'h00;
	localparam logic [7:0] OFF_CONTROL_SECOND = 8'h04;
	localparam logic [7:0] OFF_CLOCK_CONTROL  = 8'h08;
	localparam logic [7:0] OFF_INPUT_SELECT   = 8'h0C;
	localparam logic [7:0] OFF_RISING_DB      = 8'h10;
	localparam logic [7:0] OFF_FALLING_DB     = 8'h14;
	localparam logic [7:0] OFF_STEERING       = 8'h18;
	localparam logic [7:0] OFF_SHUTDOWN       = 8'h1C;
	localparam logic [7:0] OFF_STATUS         = 8'h20;

	// Field positions inside the first control register.
	localparam int BIT_ENABLE = 7;
	localparam int BIT_RELOAD = 6;
	// Field positions inside the second control register.
	localparam int BIT_DB_RISE_EN = 4;
	localparam int BIT_DB_FALL_EN = 5;
	// Field positions inside the shutdown register.
	localparam int BIT_AUTO_RESTART = 4;
	localparam int BIT_SW_SHUTDOWN  = 5;
	localparam int POS_OVERRIDE     = 8;

	// Mode field codes.
	localparam logic [2:0] MODE_STEER_ASYNC = 3'h0;
	localparam logic [2:0] MODE_STEER_SYNC  = 3'h1;
	localparam logic [2:0] MODE_FULL_FWD    = 3'h2;
	localparam logic [2:0] MODE_FULL_REV    = 3'h3;
	localparam logic [2:0] MODE_HALF        = 3'h4;
	localparam logic [2:0] MODE_PUSH_PULL   = 3'h5;

	// Reset values; polarity resets to active-high so the outputs idle low.
	localparam logic [3:0] RESET_POLARITY = 4'hF;
	localparam logic [5:0] RESET_DEADBAND = 6'h00;

	// Clock rates, used to derive the fast oscillator tick from the system clock.
	localparam int SYS_CLK_MHZ  = 125;
	localparam int FAST_OSC_MHZ = 16;
	localparam logic [7:0] OSC_STEP = 8'(FAST_OSC_MHZ);
	localparam logic [7:0] OSC_WRAP = 8'(SYS_CLK_MHZ);

endpackage : cwg_pkg

//--- rtl/complementary_waveform_gen.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Six modes chosen by mode field.
// - Half-bridge: A true, B inverted, dead time.
// - Half-bridge: C, D mirror A, B.
// - Push-pull: pulses alternate between A and B.
// - Sequencer resets when disabled or shut down.
// - First pulse after reset goes to A.
// - Push-pull: C copies A, D copies B.
// - Forward: A active, D modulated.
// - Reverse: C active, B modulated.
// - Full-bridge dead band only on direction change.
// - Direction bit changeable while running.
// - Synchronous steering applies at input rise.
// - Immediate steering applies next cycle.
// - Clock source bit picks system or 16 MHz.
// - Four-bit field selects fourteen input sources.
// - Polarity bit set means active-high output.
// - Polarity never alters overrides or shutdown.
// - Auto-shutdown works in every mode.
// - Two 6-bit dead-band timers, own enables.
// - Dead band counts zero up to value.
// - Unsteered outputs hold fixed level.
// - Active-low level shutdown overrides outputs at once.
// - Dead-band values double-buffered, reload on fall.
module complementary_waveform_gen
	import cwg_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        reset_n,
	// APB register port.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Waveform sources; the pin is asynchronous, the rest share clk.
	input  wire logic        genInputPin,
	input  wire logic        captureUnitOneOutput,
	input  wire logic        captureUnitTwoOutput,
	input  wire logic [3:0]  pwmOutputs,
	input  wire logic        oscillatorOutput,
	input  wire logic        comparatorOneSynced,
	input  wire logic        comparatorTwoSynced,
	input  wire logic [3:0]  logicCellOutputs,
	// Extra shutdown source, active low.
	input  wire logic        timerPostscaled,
	// Driver outputs.
	output logic             outA,
	output logic             outB,
	output logic             outC,
	output logic             outD
);

	// Every flip-flop of the block lives in this one record.
	typedef struct packed {
		logic [2:0]  syncPin;    // Pin synchroniser chain, bit 0 first.
		logic        pinClean;   // Pin level once two stages agree.
		logic        inPrev;     // Selected input one cycle ago.
		logic        enable;     // Module enable.
		logic        reload;     // Dead-band reload request.
		logic [2:0]  mode;       // Operating mode.
		logic [3:0]  pol;        // Output polarity bits, A in bit 0.
		logic [1:0]  dbEn;       // Dead-band enables, rise in bit 0.
		logic        clkSel;     // Generator clock source.
		logic [3:0]  inSel;      // Input source select.
		logic [5:0]  dbrBuf;     // Rising dead-band buffer.
		logic [5:0]  dbfBuf;     // Falling dead-band buffer.
		logic [5:0]  dbrWork;    // Rising dead-band working value.
		logic [5:0]  dbfWork;    // Falling dead-band working value.
		logic [3:0]  steerReq;   // Steering bits as written.
		logic [3:0]  steerAct;   // Steering bits in effect.
		logic [3:0]  fixedLvl;   // Levels of unsteered outputs.
		logic [3:0]  sdSrcEn;    // Shutdown source enables.
		logic        autoRestart;
		logic        sdSw;       // Latched shutdown state.
		logic [3:0]  ovrLvl;     // Shutdown override levels.
		logic [7:0]  oscAcc;     // Fast oscillator phase accumulator.
		logic        rBusy;      // Rising timer running.
		logic [5:0]  rCnt;
		logic        fBusy;      // Falling timer running.
		logic [5:0]  fCnt;
		logic        aOn;        // Half-bridge true output raw level.
		logic        bOn;        // Half-bridge inverted output raw level.
		logic        ppNext;     // Push-pull output for next pulse.
		logic        ppPhase;    // Push-pull output of current pulse.
		logic        dirAct;     // Full-bridge direction in effect.
		logic [3:0]  outs;       // Registered pin levels.
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} state_type;

	state_type q;        // Current state.
	state_type d;        // Next state.
	logic [13:0] srcVec; // Candidate input sources.
	logic        inNow;  // Selected input.
	logic        rise;   // Input rising edge.
	logic        fall;   // Input falling edge.
	logic        extSd;  // Any enabled external shutdown source low.
	logic        sdState; // Shutdown in force.
	logic [8:0]  accSum; // Accumulator look-ahead.
	logic        tick;   // One generator clock period elapsed.
	logic        fullMode;
	logic        steerMode;

	// Input mux; the pin enters only through its synchroniser.
	assign srcVec = {logicCellOutputs, comparatorTwoSynced, comparatorOneSynced, oscillatorOutput,
		pwmOutputs, captureUnitTwoOutput, captureUnitOneOutput, q.pinClean};
	assign inNow = (q.inSel < 4'hE) ? srcVec[q.inSel] : 1'b0;
	assign rise = inNow & ~q.inPrev;
	assign fall = ~inNow & q.inPrev;
	// Shutdown sources are active low and level sensitive.
	assign extSd = |(q.sdSrcEn & ~{q.pinClean, timerPostscaled, comparatorTwoSynced, comparatorOneSynced});
	assign sdState = q.sdSw | extSd;
	// The 16 MHz tick is a fractional divide of clk, so periods jitter by one clk.
	assign accSum = {1'b0, q.oscAcc} + {1'b0, OSC_STEP};
	assign tick = ~q.clkSel | (accSum >= {1'b0, OSC_WRAP});
	assign fullMode = (q.mode == MODE_FULL_FWD) || (q.mode == MODE_FULL_REV);
	assign steerMode = (q.mode == MODE_STEER_ASYNC) || (q.mode == MODE_STEER_SYNC);

	// Next-state logic for the whole block.
	always_comb begin
		logic [3:0] raw;
		logic       apbWr;
		logic [31:0] rd;
		raw = 4'h0;
		rd = 32'h0000_0000;
		d = q;
		apbWr = psel & penable & q.pready & pwrite;
		// Synchroniser: the first stage is read only by the second.
		d.syncPin = {q.syncPin[1:0], genInputPin};
		if (q.syncPin[1] == q.syncPin[2]) begin
			d.pinClean = q.syncPin[2];
		end
		d.inPrev = inNow;
		// Fast oscillator accumulator.
		if (q.clkSel && tick) begin
			d.oscAcc = 8'(accSum - {1'b0, OSC_WRAP});
		end else if (q.clkSel) begin
			d.oscAcc = accSum[7:0];
		end
		// Dead-band timers count generator periods from zero to the value.
		if (q.rBusy && tick) begin
			if (q.rCnt == q.dbrWork - 6'h01) begin
				d.rBusy = 1'b0;
				d.aOn = (q.mode == MODE_HALF) ? 1'b1 : q.aOn;
			end else begin
				d.rCnt = q.rCnt + 6'h01;
			end
		end
		if (q.fBusy && tick) begin
			if (q.fCnt == q.dbfWork - 6'h01) begin
				d.fBusy = 1'b0;
				d.bOn = (q.mode == MODE_HALF) ? 1'b1 : q.bOn;
			end else begin
				d.fCnt = q.fCnt + 6'h01;
			end
		end
		// Half-bridge edges; a pulse shorter than the dead band never appears.
		if (q.mode == MODE_HALF) begin
			if (rise) begin
				d.bOn = 1'b0;
				d.fBusy = 1'b0;
				if (q.dbEn[0] && q.dbrWork != RESET_DEADBAND) begin
					d.rBusy = 1'b1;
					d.rCnt = RESET_DEADBAND;
				end else begin
					d.aOn = 1'b1;
				end
			end else if (fall) begin
				d.aOn = 1'b0;
				d.rBusy = 1'b0;
				if (q.dbEn[1] && q.dbfWork != RESET_DEADBAND) begin
					d.fBusy = 1'b1;
					d.fCnt = RESET_DEADBAND;
				end else begin
					d.bOn = 1'b1;
				end
			end
		end
		// Direction change takes effect at the next rise, delayed by dead band.
		if (fullMode && rise && (q.mode[0] != q.dirAct)) begin
			d.dirAct = q.mode[0];
			if (q.mode[0] && q.dbEn[0] && q.dbrWork != RESET_DEADBAND) begin
				d.rBusy = 1'b1;
				d.rCnt = RESET_DEADBAND;
			end else if (!q.mode[0] && q.dbEn[1] && q.dbfWork != RESET_DEADBAND) begin
				d.fBusy = 1'b1;
				d.fCnt = RESET_DEADBAND;
			end
		end
		// Push-pull sequencer.
		if (q.mode == MODE_PUSH_PULL && rise) begin
			d.ppPhase = q.ppNext;
			d.ppNext = ~q.ppNext;
		end
		// Steering selection update.
		if (q.mode == MODE_STEER_ASYNC || (q.mode == MODE_STEER_SYNC && rise)) begin
			d.steerAct = q.steerReq;
		end
		// Consume a pending reload on the falling input edge.
		if (q.enable && q.reload && fall) begin
			d.dbrWork = q.dbrBuf;
			d.dbfWork = q.dbfBuf;
			d.reload = 1'b0;
		end
		// Auto-restart clears a software shutdown at a rising edge.
		if (q.autoRestart && rise && !extSd) begin
			d.sdSw = 1'b0;
		end
		// Register writes, taken at the edge where pready is sampled high.
		if (apbWr) begin
			unique case (paddr)
				OFF_CONTROL_FIRST: begin
					d.enable = pwdata[BIT_ENABLE];
					d.reload = q.reload | pwdata[BIT_RELOAD];
					d.mode = pwdata[2:0];
				end
				OFF_CONTROL_SECOND: begin
					d.pol = pwdata[3:0];
					d.dbEn = {pwdata[BIT_DB_FALL_EN], pwdata[BIT_DB_RISE_EN]};
				end
				OFF_CLOCK_CONTROL: d.clkSel = pwdata[0];
				OFF_INPUT_SELECT: d.inSel = pwdata[3:0];
				OFF_RISING_DB: d.dbrBuf = pwdata[5:0];
				OFF_FALLING_DB: d.dbfBuf = pwdata[5:0];
				OFF_STEERING: begin
					d.steerReq = pwdata[3:0];
					d.fixedLvl = pwdata[7:4];
				end
				OFF_SHUTDOWN: begin
					d.sdSrcEn = pwdata[3:0];
					d.autoRestart = pwdata[BIT_AUTO_RESTART];
					d.sdSw = pwdata[BIT_SW_SHUTDOWN];
					d.ovrLvl = pwdata[POS_OVERRIDE +: 4];
				end
				default: ;
			endcase
		end
		// An active source wins over a software clear in the same cycle.
		if (extSd) begin
			d.sdSw = 1'b1;
		end
		// While disabled, buffers load straight into the working values.
		if (!q.enable) begin
			d.dbrWork = d.dbrBuf;
			d.dbfWork = d.dbfBuf;
		end
		// Disable or shutdown returns the sequencer and timers to idle.
		if (!q.enable || sdState) begin
			d.ppNext = 1'b0;
			d.ppPhase = 1'b0;
			d.rBusy = 1'b0;
			d.fBusy = 1'b0;
		end
		if (!q.enable) begin // Shutdown keeps these, so the pins resume as they were once it clears.
			d.aOn = 1'b0;
			d.bOn = 1'b0;
		end
		// Raw active levels per mode, A in bit 0.
		unique case (q.mode)
			MODE_HALF: raw = {q.bOn, q.aOn, q.bOn, q.aOn};
			MODE_PUSH_PULL: raw = {2{inNow & d.ppPhase, inNow & ~d.ppPhase}}; // New phase avoids a stray lead pulse.
			MODE_FULL_FWD, MODE_FULL_REV: begin
				if (q.dirAct) begin
					raw = {1'b0, 1'b1, inNow & ~q.rBusy, 1'b0};
				end else begin
					raw = {inNow & ~q.fBusy, 1'b0, 1'b0, 1'b1};
				end
			end
			default: raw = {4{inNow}};
		endcase
		// Pin levels: polarity applies to active drive and the disabled level only.
		if (!q.enable) begin
			d.outs = ~q.pol;
		end else if (steerMode) begin
			for (int i = 0; i < 4; i++) begin
				if (!q.steerAct[i]) begin
					d.outs[i] = q.fixedLvl[i];
				end else if (sdState) begin
					d.outs[i] = q.ovrLvl[i];
				end else begin
					d.outs[i] = inNow ^ ~q.pol[i];
				end
			end
		end else if (sdState) begin
			d.outs = q.ovrLvl;
		end else begin
			d.outs = raw ^ ~q.pol;
		end
		// APB answer: one wait state, then ready with data.
		d.pready = psel & penable & ~q.pready;
		if (d.pready) begin
			d.pslverr = 1'b0;
			unique case (paddr)
				OFF_CONTROL_FIRST: rd = {24'h00_0000, q.enable, q.reload, 3'h0, q.mode};
				OFF_CONTROL_SECOND: rd = {26'h000_0000, q.dbEn, q.pol};
				OFF_CLOCK_CONTROL: rd = {31'h0000_0000, q.clkSel};
				OFF_INPUT_SELECT: rd = {28'h000_0000, q.inSel};
				OFF_RISING_DB: rd = {26'h000_0000, q.dbrBuf};
				OFF_FALLING_DB: rd = {26'h000_0000, q.dbfBuf};
				OFF_STEERING: rd = {24'h00_0000, q.fixedLvl, q.steerReq};
				OFF_SHUTDOWN: rd = {20'h0_0000, q.ovrLvl, 2'h0, sdState, q.autoRestart, q.sdSrcEn};
				OFF_STATUS: rd = {27'h000_0000, sdState, q.outs};
				default: d.pslverr = 1'b1;
			endcase
			d.prdata = rd;
		end
	end

	// State register; reset leaves the block disabled and idle.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
			q.pol <= RESET_POLARITY;
		end else begin
			q <= d;
		end
	end

	assign pready = q.pready;
	assign prdata = q.prdata;
	assign pslverr = q.pslverr;
	assign outA = q.outs[0];
	assign outB = q.outs[1];
	assign outC = q.outs[2];
	assign outD = q.outs[3];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	chk_pp_seq_reset: assert property (!q.enable |=> !q.ppNext)
		else $error("push-pull sequencer not reset while disabled");
	chk_pp_alternate: assert property (q.enable && !sdState && q.mode == MODE_PUSH_PULL && rise
		|=> q.ppPhase == $past(q.ppNext) && q.ppNext != $past(q.ppNext))
		else $error("push-pull pulses did not alternate");
	chk_disabled_out: assert property (!q.enable |=> q.outs == ~$past(q.pol))
		else $error("outputs not inactive while disabled");
	chk_shutdown_override: assert property (q.enable && sdState && !steerMode |=> q.outs == $past(q.ovrLvl))
		else $error("shutdown override not applied");
	chk_forward_static: assert property (q.enable && !sdState && fullMode && !q.dirAct
		|=> q.outs[2:0] == $past({~q.pol[2], ~q.pol[1], q.pol[0]}))
		else $error("forward full-bridge static levels wrong");
	chk_reverse_static: assert property (q.enable && !sdState && fullMode && q.dirAct
		|=> {q.outs[3], q.outs[2], q.outs[0]} == $past({~q.pol[3], q.pol[2], ~q.pol[0]}))
		else $error("reverse full-bridge static levels wrong");
	chk_sync_steer_hold: assert property (q.mode == MODE_STEER_SYNC && !rise |=> $stable(q.steerAct))
		else $error("synchronous steering changed without a rising edge");
	chk_db_reload_hold: assert property (q.enable && !fall |=> $stable(q.dbrWork) && $stable(q.dbfWork))
		else $error("dead-band working value changed outside a falling edge");
	chk_db_count_bound: assert property (q.rBusy |-> q.rCnt < q.dbrWork)
		else $error("rising dead-band counter passed its value");
	cov_half_bridge: cover property (q.enable && q.mode == MODE_HALF && q.rBusy ##[1:70] q.aOn);
	cov_push_pull: cover property (q.enable && q.mode == MODE_PUSH_PULL && rise ##[1:200] rise && q.ppPhase);
	cov_direction: cover property (fullMode && rise && q.mode[0] != q.dirAct);
	cov_shutdown: cover property (q.enable && extSd);

endmodule : complementary_waveform_gen

`default_nettype wire

//--- tb/bridge_driver_model.sv
`timescale 1ns/1ps
`default_nettype none

// External bridge drivers: one leg is A/B, the other C/D; a leg with both switches on shorts the rail.
module bridge_driver_model (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Gate drive levels from the generator, bit 0 is A.
	input  wire logic [3:0]  gateDrive,
	// Cycles seen with a leg shorted.
	output logic      [15:0] overlapCount
);
	// Count every cycle in which a leg conducts on both switches; the bench expects none.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			overlapCount <= 16'h0000;
		end else if ((gateDrive[0] & gateDrive[1]) | (gateDrive[2] & gateDrive[3])) begin
			overlapCount <= overlapCount + 16'h0001;
		end
	end
endmodule : bridge_driver_model
`default_nettype wire

//--- tb/complementary_waveform_gen_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] %0t %s", $time, m); end end

module complementary_waveform_gen_tb_top
	import cwg_pkg::*;
;
	logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, timerPostscaled;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [13:0] srcVec;     // One bit per selectable source, in select-code order.
	logic        outA, outB, outC, outD;
	logic [15:0] overlapCount;
	wire  [3:0]  outs = {outD, outC, outB, outA};
	int          mismatches, num_checks;

	// Device under test with every source driven from the bench.
	complementary_waveform_gen u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.genInputPin(srcVec[0]), .captureUnitOneOutput(srcVec[1]), .captureUnitTwoOutput(srcVec[2]),
		.pwmOutputs(srcVec[6:3]), .oscillatorOutput(srcVec[7]), .comparatorOneSynced(srcVec[8]),
		.comparatorTwoSynced(srcVec[9]), .logicCellOutputs(srcVec[13:10]), .timerPostscaled(timerPostscaled),
		.outA(outA), .outB(outB), .outC(outC), .outD(outD));

	// Far-side drivers watching for shoot-through.
	bridge_driver_model u_drv (.clk(clk), .reset_n(reset_n), .gateDrive(outs), .overlapCount(overlapCount));

	// Free-running 8 ns clock.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// One APB transfer; pready and prdata are read at the rising edge, before that edge's updates land.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			`CHK(1'b0, 1'b1, "bus timeout")
			give_verdict();
		end else begin
			rdv = prdata;
			psel <= 1'b0; penable <= 1'b0;
		end
	endtask : apb

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(rdv, e, "read data")
	endtask : rdchk

	// Drive the selected input and let it reach the pins.
	task automatic setIn(input logic v);
		@(posedge clk) srcVec[1] <= v;
		cyc(3);
	endtask : setIn

	function automatic logic [31:0] ctl(input logic en, input logic [2:0] m);
		return {24'h00_0000, en, 4'h0, m};
	endfunction : ctl

	task automatic test_reset;
		`CHK(outs, 4'h0, "outputs after reset")
		rdchk(OFF_CONTROL_FIRST, 32'h0000_0000);
		rdchk(OFF_CONTROL_SECOND, 32'h0000_000F);
		rdchk(8'h40, 32'h0000_0000);
		`CHK(pslverr, 1'b1, "unmapped address")
		apb(1'b1, OFF_CLOCK_CONTROL, 32'h0000_0001);
		rdchk(OFF_CLOCK_CONTROL, 32'h0000_0001);
		apb(1'b1, OFF_CLOCK_CONTROL, 32'h0000_0000);
		$display("test_reset done");
	endtask : test_reset

	task automatic test_half;
		apb(1'b1, OFF_INPUT_SELECT, 32'h0000_0001);
		apb(1'b1, OFF_CONTROL_FIRST, ctl(1'b1, MODE_HALF));
		setIn(1'b1);
		`CHK(outs, 4'h5, "half high")
		setIn(1'b0);
		`CHK(outs, 4'hA, "half low")
		apb(1'b1, OFF_CONTROL_SECOND, 32'h0000_0003);
		setIn(1'b1);
		`CHK(outs, 4'h9, "half polarity high")
		setIn(1'b0);
		`CHK(outs, 4'h6, "half polarity low")
		apb(1'b1, OFF_CONTROL_SECOND, 32'h0000_000F);
		$display("test_half done");
	endtask : test_half

	task automatic test_push;
		apb(1'b1, OFF_CONTROL_FIRST, ctl(1'b1, MODE_PUSH_PULL));
		for (int k = 0; k < 3; k++) begin
			if (k == 2) begin
				apb(1'b1, OFF_CONTROL_FIRST, ctl(1'b0, MODE_PUSH_PULL));
				apb(1'b1, OFF_CONTROL_FIRST, ctl(1'b1, MODE_PUSH_PULL));
			end
			setIn(1'b1);
			`CHK(outs, (k == 1) ? 4'hA : 4'h5, "push-pull pulse")
			setIn(1'b0);
			`CHK(outs, 4'h0, "push-pull gap")
		end
		$display("test_push done");
	endtask : test_push

	task automatic test_full;
		apb(1'b1, OFF_CONTROL_FIRST, ctl(1'b1, MODE_FULL_FWD));
		setIn(1'b1);
		`CHK(outs, 4'h9, "forward high")
		setIn(1'b0);
		`CHK(outs, 4'h1, "forward low")
		apb(1'b1, OFF_CONTROL_FIRST, ctl(1'b1, MODE_FULL_REV));
		setIn(1'b1);
		cyc(3);
		`CHK(outs, 4'h6, "reverse high")
		setIn(1'b0);
		`CHK(outs, 4'h4, "reverse low")
		// Spare mode codes follow the input on every pin; mixed polarity keeps each leg safe.
		apb(1'b1, OFF_CONTROL_FIRST, ctl(1'b1, 3'h6));
		apb(1'b1, OFF_CONTROL_SECOND, 32'h0000_0005);
		setIn(1'b1);
		`CHK(outs, 4'h5, "spare mode high")
		setIn(1'b0);
		`CHK(outs, 4'hA, "spare mode low")
		apb(1'b1, OFF_CONTROL_SECOND, 32'h0000_000F);
		$display("test_full done");
	endtask : test_full

	// A disabled write loads the dead band at once; the leading edge of A then lags by the count.
	task automatic test_deadband;
		apb(1'b1, OFF_CONTROL_FIRST, ctl(1'b0, MODE_HALF));
		apb(1'b1, OFF_RISING_DB, 32'h0000_0008);
		rdchk(OFF_RISING_DB, 32'h0000_0008);
		apb(1'b1, OFF_CONTROL_SECOND, 32'h0000_001F);
		apb(1'b1, OFF_CONTROL_FIRST, ctl(1'b1, MODE_HALF));
		cyc(3);
		setIn(1'b1);
		`CHK({outB, outA}, 2'b00, "rising dead time")
		cyc(7);
		`CHK({outB, outA}, 2'b00, "last cycle of dead time")
		cyc(1);
		`CHK({outB, outA}, 2'b01, "after dead time")
		setIn(1'b0);
		// While enabled a new value waits for the reload request and the next falling edge.
		apb(1'b1, OFF_RISING_DB, 32'h0000_0004);
		apb(1'b1, OFF_CONTROL_FIRST, ctl(1'b1, MODE_HALF) | 32'h0000_0040);
		setIn(1'b1);
		cyc(7);
		`CHK(outA, 1'b0, "old dead band kept while enabled")
		setIn(1'b0);
		setIn(1'b1);
		cyc(3);
		`CHK(outA, 1'b0, "reloaded dead time")
		cyc(1);
		`CHK(outA, 1'b1, "reloaded dead time ends")
		setIn(1'b0);
		apb(1'b1, OFF_CONTROL_SECOND, 32'h0000_000F);
		$display("test_deadband done");
	endtask : test_deadband

	task automatic test_steer;
		apb(1'b1, OFF_CONTROL_FIRST, ctl(1'b1, MODE_STEER_ASYNC));
		setIn(1'b1);
		apb(1'b1, OFF_STEERING, 32'h0000_0041);
		cyc(3);
		`CHK(outs, 4'h5, "steered and fixed")
		apb(1'b1, OFF_STEERING, 32'h0000_0040);
		cyc(3);
		`CHK(outs, 4'h4, "immediate steering")
		apb(1'b1, OFF_CONTROL_FIRST, ctl(1'b1, MODE_STEER_SYNC));
		apb(1'b1, OFF_STEERING, 32'h0000_0001);
		cyc(2);
		`CHK(outA, 1'b0, "sync waits for rise")
		setIn(1'b0);
		setIn(1'b1);
		`CHK(outs, 4'h1, "sync applied at rise")
		$display("test_steer done");
	endtask : test_steer

	// Every source code routes its own source to the steered output.
	task automatic test_select;
		for (int i = 0; i < 14; i++) begin
			apb(1'b1, OFF_INPUT_SELECT, 32'(i));
			@(posedge clk) srcVec <= 14'(1) << i;
			cyc(8);
			`CHK(outA, 1'b1, "source high")
			@(posedge clk) srcVec <= 14'h0000;
			cyc(8);
			`CHK(outA, 1'b0, "source low")
		end
		// An unused code selects nothing, even with every source high.
		apb(1'b1, OFF_INPUT_SELECT, 32'h0000_000E);
		@(posedge clk) srcVec <= 14'h3FFF;
		cyc(8);
		`CHK(outA, 1'b0, "unused select code")
		@(posedge clk) srcVec <= 14'h0000;
		apb(1'b1, OFF_INPUT_SELECT, 32'h0000_0001);
		$display("test_select done");
	endtask : test_select

	task automatic test_shutdown;
		apb(1'b1, OFF_CONTROL_FIRST, ctl(1'b1, MODE_HALF));
		apb(1'b1, OFF_CONTROL_SECOND, 32'h0000_0003);
		apb(1'b1, OFF_SHUTDOWN, 32'h0000_0A04);
		setIn(1'b1);
		@(posedge clk) timerPostscaled <= 1'b0;
		cyc(2);
		`CHK(outs, 4'hA, "override levels")
		rdchk(OFF_STATUS, 32'h0000_001A);
		@(posedge clk) timerPostscaled <= 1'b1;
		cyc(3);
		`CHK(outs, 4'hA, "shutdown held")
		apb(1'b1, OFF_SHUTDOWN, 32'h0000_0A04);
		cyc(3);
		`CHK(outs, 4'h9, "shutdown cleared")
		$display("test_shutdown done");
	endtask : test_shutdown

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict

	// Main sequence.
	initial begin
		mismatches = 0; num_checks = 0;
		reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0000_0000; srcVec = 14'h0000; timerPostscaled = 1'b1;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		cyc(2);
		test_reset();
		test_half();
		test_push();
		test_full();
		test_deadband();
		test_steer();
		test_select();
		test_shutdown();
		`CHK(overlapCount, 16'h0000, "leg shoot-through")
		give_verdict();
	end
endmodule : complementary_waveform_gen_tb_top
`default_nettype wire
